// [rtl/ulf_defs.vh]
`ifndef ULF_DEFS_VH
`define ULF_DEFS_VH
// ----------------------------------------
// Register map (word index, byte addr = 4*index)
// ----------------------------------------
`define ULF_ADDR_W 4
`define ULF_IDX_LINE_CTRL 4'h3
`define ULF_IDX_MODEM_CTRL 4'h4
`define ULF_IDX_DIV_LOW 4'h0
`define ULF_IDX_DIV_HIGH 4'h1
`define ULF_IDX_STATE 4'h7
`define ULF_IDX_TX_DATA 4'h8
`define ULF_IDX_RX_DATA 4'h9
// ----------------------------------------
// Line control fields
// ----------------------------------------
`define ULF_LC_DLS_LO 0
`define ULF_LC_DLS_HI 1
`define ULF_LC_STOP 2
`define ULF_LC_PEN 3
`define ULF_LC_EPS 4
`define ULF_LC_BC 6
`define ULF_LC_DIVISOR_ACCESS_BIT 7
`define ULF_LC_RESET 8'h00
`define ULF_LC_FMT_MASK 8'h1f
// ----------------------------------------
// Modem control fields
// ----------------------------------------
`define ULF_MC_LB 4
`define ULF_MC_SIR 6
`define ULF_MC_RESET 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define ULF_DIV_RESET 16'h0001
`define ULF_OVS 16
`define ULF_HALF_OVS 8
`endif

// [rtl/ulf_fmt.v]
`timescale 1ns/1ps
// Decodes character format from line control bits
module ulf_fmt (
	input wire [1:0] i_dls, // Data length code
	input wire i_stop, // Stop select
	output wire [3:0] o_data_bits, // Data bits 5..8
	output wire [5:0] o_stop_ticks // Stop length in oversample ticks
);
	assign o_data_bits = {2'b00, i_dls} + 4'h5;
	// 16, 24 for 1.5 at five bits, 32 otherwise
	assign o_stop_ticks = !i_stop ? 6'h10 : (i_dls == 2'b00 ? 6'h18 : 6'h20);
endmodule

// [rtl/ulf_top.v]
`timescale 1ns/1ps
`include "ulf_defs.vh"
module ulf_top (
	input wire i_sys_clk, // Clock 50 MHz
	input wire i_sys_rst, // Sync reset, active high
	input wire i_ce, // Clock enable
	input wire [`ULF_ADDR_W-1:0] i_addr, // Word index
	input wire [15:0] i_wdata, // Write data
	input wire i_wr, // Write strobe
	input wire i_rd, // Read strobe
	output reg [15:0] o_rdata_q, // Read data, cycle after strobe
	input wire i_rx_pin, // Serial input pin
	input wire i_sir_in, // Infrared input pin
	output reg o_tx_q, // Serial output pin
	output reg o_sir_out_n_q, // Infrared output, active low
	output reg o_rx_valid_q, // Received character pulse
	output reg o_parity_err_q, // Parity error with character
	output reg o_frame_err_q // Framing error with character
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] lc_q;
	reg [7:0] mc_q;
	reg [15:0] div_q;
	reg [7:0] thr_q;
	reg thr_full_q;
	reg [7:0] rbr_q;
	reg [1:0] rx_sync_q;
	reg [1:0] sir_sync_q;
	wire [3:0] data_bits;
	wire [5:0] stop_ticks;
	wire busy;
	wire lb = mc_q[`ULF_MC_LB];
	wire sir = mc_q[`ULF_MC_SIR];
	wire brk = lc_q[`ULF_LC_BC];
	wire divisor_access_bit = lc_q[`ULF_LC_DIVISOR_ACCESS_BIT];

	function sel;
		input [`ULF_ADDR_W-1:0] a;
		input [`ULF_ADDR_W-1:0] idx;
		sel = (a == idx);
	endfunction

	ulf_fmt u_fmt (
		.i_dls(lc_q[`ULF_LC_DLS_HI:`ULF_LC_DLS_LO]),
		.i_stop(lc_q[`ULF_LC_STOP]),
		.o_data_bits(data_bits),
		.o_stop_ticks(stop_ticks)
	);

	// ----------------------------------------
	// Oversample tick
	// ----------------------------------------
	reg [15:0] baud_cnt_q;
	reg tick_q;
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			baud_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (i_ce) begin
			tick_q <= 1'b0;
			if (baud_cnt_q + 16'h0001 >= div_q) begin
				baud_cnt_q <= 16'h0000;
				tick_q <= 1'b1;
			end else begin
				baud_cnt_q <= baud_cnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	localparam TX_IDLE = 5'b00001;
	localparam TX_START = 5'b00010;
	localparam TX_DATA = 5'b00100;
	localparam TX_PAR = 5'b01000;
	localparam TX_STOP = 5'b10000;
	reg [4:0] tx_st_q;
	reg [5:0] tx_tick_q;
	reg [2:0] tx_bit_q;
	reg [7:0] tx_sh_q;
	reg tx_par_q;
	reg tx_line_q;
	// Format is sampled per bit; busy lock keeps it stable mid-character
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			tx_st_q <= TX_IDLE;
			tx_tick_q <= 6'h00;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			tx_par_q <= 1'b0;
			tx_line_q <= 1'b1;
		end else if (i_ce && tick_q) begin
			case (tx_st_q)
			TX_IDLE: begin
				tx_line_q <= 1'b1;
				tx_tick_q <= 6'h00;
				if (thr_full_q) begin
					tx_sh_q <= thr_q;
					tx_par_q <= ~lc_q[`ULF_LC_EPS];
					tx_line_q <= 1'b0;
					tx_st_q <= TX_START;
				end
			end
			TX_START: begin
				tx_tick_q <= tx_tick_q + 6'h01;
				if (tx_tick_q == `ULF_OVS - 1) begin
					tx_tick_q <= 6'h00;
					tx_bit_q <= 3'h0;
					tx_line_q <= tx_sh_q[0];
					tx_st_q <= TX_DATA;
				end
			end
			TX_DATA: begin
				tx_tick_q <= tx_tick_q + 6'h01;
				if (tx_tick_q == `ULF_OVS - 1) begin
					tx_tick_q <= 6'h00;
					tx_par_q <= tx_par_q ^ tx_sh_q[0];
					tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					tx_bit_q <= tx_bit_q + 3'h1;
					if ({1'b0, tx_bit_q} == data_bits - 4'h1) begin
						if (lc_q[`ULF_LC_PEN]) begin
							tx_line_q <= tx_par_q ^ tx_sh_q[0];
							tx_st_q <= TX_PAR;
						end else begin
							tx_line_q <= 1'b1;
							tx_st_q <= TX_STOP;
						end
					end else begin
						tx_line_q <= tx_sh_q[1];
					end
				end
			end
			TX_PAR: begin
				tx_tick_q <= tx_tick_q + 6'h01;
				if (tx_tick_q == `ULF_OVS - 1) begin
					tx_tick_q <= 6'h00;
					tx_line_q <= 1'b1;
					tx_st_q <= TX_STOP;
				end
			end
			TX_STOP: begin
				tx_tick_q <= tx_tick_q + 6'h01;
				if (tx_tick_q == stop_ticks - 6'h01) begin
					tx_tick_q <= 6'h00;
					tx_st_q <= TX_IDLE;
				end
			end
			default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// Serial output after break forcing
	wire sout = tx_line_q & ~brk;
	reg [3:0] sir_cnt_q;
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			sir_cnt_q <= 4'h0;
		end else if (i_ce && tick_q) begin
			sir_cnt_q <= sir_cnt_q + 4'h1;
		end
	end
	// Infrared: low pulse 3/16 of a zero bit
	wire sir_pulse = (sir_cnt_q >= 4'h7) && (sir_cnt_q <= 4'h9);

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rx_sync_q <= 2'b11;
			sir_sync_q <= 2'b11;
		end else if (i_ce) begin
			rx_sync_q <= {rx_sync_q[0], i_rx_pin};
			sir_sync_q <= {sir_sync_q[0], i_sir_in};
		end
	end
	// Loopback feeds serial output back uninverted, also in infrared mode
	wire rx_in = lb ? sout : (sir ? sir_sync_q[1] : rx_sync_q[1]);

	localparam RX_IDLE = 4'b0001;
	localparam RX_DATA = 4'b0010;
	localparam RX_PAR = 4'b0100;
	localparam RX_STOP = 4'b1000;
	reg [3:0] rx_st_q;
	reg [3:0] rx_tick_q;
	reg [2:0] rx_bit_q;
	reg [7:0] rx_sh_q;
	reg rx_par_q;
	reg rx_start_q;
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rx_st_q <= RX_IDLE;
			rx_start_q <= 1'b0;
			rx_tick_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_par_q <= 1'b0;
			rbr_q <= 8'h00;
			o_rx_valid_q <= 1'b0;
			o_parity_err_q <= 1'b0;
			o_frame_err_q <= 1'b0;
		end else if (i_ce) begin
			o_rx_valid_q <= 1'b0;
			if (tick_q) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				case (rx_st_q)
				RX_IDLE: begin
					rx_tick_q <= 4'h0;
					if (!rx_in) begin
						rx_tick_q <= 4'h0 - 4'd`ULF_HALF_OVS;
						rx_start_q <= 1'b1;
						rx_bit_q <= 3'h0;
						rx_sh_q <= 8'h00;
						rx_par_q <= ~lc_q[`ULF_LC_EPS];
						rx_st_q <= RX_DATA;
					end
				end
				RX_DATA: if (rx_tick_q == 4'hf) begin
					if (rx_start_q) begin
						// Mid start bit: a high line here was only a glitch
						rx_start_q <= 1'b0;
						if (rx_in) begin
							rx_st_q <= RX_IDLE;
						end
					end else begin
						rx_sh_q <= {rx_in, rx_sh_q[7:1]};
						rx_par_q <= rx_par_q ^ rx_in;
						rx_bit_q <= rx_bit_q + 3'h1;
						if ({1'b0, rx_bit_q} == data_bits - 4'h1) begin
							rx_st_q <= lc_q[`ULF_LC_PEN] ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: if (rx_tick_q == 4'hf) begin
					o_parity_err_q <= rx_par_q ^ rx_in;
					rx_st_q <= RX_STOP;
				end
				RX_STOP: if (rx_tick_q == 4'hf) begin
					// Only first stop bit sampled; later ones seen as idle
					o_frame_err_q <= ~rx_in;
					if (!lc_q[`ULF_LC_PEN]) begin
						o_parity_err_q <= 1'b0;
					end
					rbr_q <= rx_sh_q >> (4'h8 - data_bits);
					o_rx_valid_q <= 1'b1;
					rx_st_q <= RX_IDLE;
				end
				default: rx_st_q <= RX_IDLE;
				endcase
			end
		end
	end

	assign busy = (tx_st_q != TX_IDLE) | thr_full_q | (rx_st_q != RX_IDLE);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	wire wr_lc = i_wr && sel(i_addr, `ULF_IDX_LINE_CTRL);
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			lc_q <= `ULF_LC_RESET;
			mc_q <= `ULF_MC_RESET;
			div_q <= `ULF_DIV_RESET;
			thr_q <= 8'h00;
			thr_full_q <= 1'b0;
		end else if (i_ce) begin
			if (tick_q && tx_st_q == TX_IDLE && thr_full_q) begin
				thr_full_q <= 1'b0;
			end
			if (wr_lc) begin
				lc_q[`ULF_LC_BC] <= i_wdata[`ULF_LC_BC];
				if (!busy) begin
					lc_q[`ULF_LC_DIVISOR_ACCESS_BIT] <= i_wdata[`ULF_LC_DIVISOR_ACCESS_BIT];
					lc_q[4:0] <= i_wdata[4:0];
				end
			end
			if (i_wr && sel(i_addr, `ULF_IDX_MODEM_CTRL)) begin
				mc_q[`ULF_MC_LB] <= i_wdata[`ULF_MC_LB];
				mc_q[`ULF_MC_SIR] <= i_wdata[`ULF_MC_SIR];
			end
			if (i_wr && divisor_access_bit && sel(i_addr, `ULF_IDX_DIV_LOW)) begin
				div_q[7:0] <= i_wdata[7:0];
			end
			if (i_wr && divisor_access_bit && sel(i_addr, `ULF_IDX_DIV_HIGH)) begin
				div_q[15:8] <= i_wdata[7:0];
			end
			if (i_wr && !divisor_access_bit && sel(i_addr, `ULF_IDX_TX_DATA) && !thr_full_q) begin
				thr_q <= i_wdata[7:0];
				thr_full_q <= 1'b1;
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_rdata_q <= 16'h0000;
		end else if (i_ce) begin
			o_rdata_q <= 16'h0000;
			if (i_rd) begin
				case (i_addr)
				`ULF_IDX_LINE_CTRL: o_rdata_q <= {8'h00, lc_q};
				`ULF_IDX_MODEM_CTRL: o_rdata_q <= {8'h00, mc_q};
				`ULF_IDX_DIV_LOW: o_rdata_q <= divisor_access_bit ? {8'h00, div_q[7:0]} : 16'h0000;
				`ULF_IDX_DIV_HIGH: o_rdata_q <= divisor_access_bit ? {8'h00, div_q[15:8]} : 16'h0000;
				`ULF_IDX_STATE: o_rdata_q <= {15'h0000, busy};
				`ULF_IDX_RX_DATA: o_rdata_q <= divisor_access_bit ? 16'h0000 : {8'h00, rbr_q};
				default: o_rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_tx_q <= 1'b1;
			o_sir_out_n_q <= 1'b1;
		end else if (i_ce) begin
			if (lb) begin
				o_tx_q <= 1'b1;
				o_sir_out_n_q <= 1'b0;
			end else begin
				o_tx_q <= sout;
				// Zero bits, including break, pulse the infrared line
				o_sir_out_n_q <= sir ? ~(~sout & sir_pulse) : 1'b1;
			end
		end
	end
endmodule

// [test/ulf_top_props.sv]
`timescale 1ns/1ps
module ulf_top_props (
	input wire i_sys_clk, // Clock
	input wire i_sys_rst, // Reset
	input wire i_ce, // Enable
	input wire [3:0] i_addr, // Index
	input wire [15:0] i_wdata, // Data
	input wire i_wr, // Write
	input wire i_rd, // Read
	input wire [15:0] o_rdata_q, // Read data
	input wire o_tx_q, // Serial out
	input wire o_sir_out_n_q, // IR out
	input wire o_rx_valid_q // Rx pulse
);
	reg brk_q, lb_q, ir_q;
	reg [4:0] qt_q, hi_q;
	wire mc_wr = i_wr && i_addr == 4'h4;
	wire set = qt_q > 5'h02;
	// Only always-writable bits mirrored, format bits may be refused
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			{brk_q, lb_q, ir_q} <= 3'h0;
			qt_q <= 5'h00;
			hi_q <= 5'h00;
		end else if (i_ce) begin
			if (i_wr && i_addr == 4'h3)
				brk_q <= i_wdata[6];
			if (mc_wr)
				{ir_q, lb_q} <= {i_wdata[6], i_wdata[4]};
			qt_q <= (mc_wr || (i_wr && i_addr == 4'h3)) ? 5'h00 : qt_q + {4'h0, ~&qt_q};
			hi_q <= o_sir_out_n_q ? hi_q + {4'h0, ~&hi_q} : 5'h00;
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	AST_RST_IDLE: assert property ($fell(i_sys_rst) |-> o_tx_q && o_sir_out_n_q && !o_rx_valid_q)
		else $error("idle level after reset");
	AST_RD_ZERO: assert property (i_ce && !i_rd |=> o_rdata_q == 16'h0000)
		else $error("read data outside answer");
	AST_BRK_LOW: assert property (brk_q && !lb_q && set |-> !o_tx_q)
		else $error("break not low");
	AST_LB_HIGH: assert property (lb_q && !ir_q && set |-> o_tx_q)
		else $error("loopback line not high");
	AST_LB_IR_LOW: assert property (lb_q && brk_q && set |-> !o_sir_out_n_q)
		else $error("loopback ir not low");
	AST_IR_PULSE: assert property (ir_q && brk_q && !lb_q && qt_q > 5'h13 |-> hi_q < 5'h12)
		else $error("ir break static");
	AST_IR_SHORT: assert property ($fell(o_sir_out_n_q) && !lb_q && set |-> ##[1:4] o_sir_out_n_q)
		else $error("ir pulse too long");
	AST_RXV_PULSE: assert property (o_rx_valid_q |=> !o_rx_valid_q)
		else $error("rx pulse too long");
	AST_BIT_LEN: assert property ($fell(o_tx_q) && !brk_q && set |-> !o_tx_q [*8])
		else $error("short low bit");
endmodule
bind ulf_top ulf_top_props u_props (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata_q(o_rdata_q), .o_tx_q(o_tx_q),
	.o_sir_out_n_q(o_sir_out_n_q), .o_rx_valid_q(o_rx_valid_q));

// [test/ulf_remote.sv]
`timescale 1ns/1ps
module ulf_remote (
	input wire i_clk, // Bench clock
	input wire i_line, // Block serial out
	input wire [3:0] i_nsmp, // Bits kept after start
	output reg o_line // Block serial in
);
	time last_t = 0;
	time period = 0;
	reg [8:0] smp = 9'h000;
	integer k;
	initial o_line = 1'b1;
	// Mid-bit sampling, 16 clocks a bit at divisor one
	always begin
		@(negedge i_line);
		period = $time - last_t;
		last_t = $time;
		repeat (8) @(posedge i_clk);
		for (k = 0; k < i_nsmp; k = k + 1) begin
			repeat (16) @(posedge i_clk);
			smp[k] = i_line;
		end
		wait (i_line);
	end
	// Line returns high after each frame, as a pulled-up idle
	task send(input [10:0] bits, input integer n);
		reg [11:0] f;
		integer b;
		begin
			f = {bits, 1'b0};
			for (b = 0; b <= n; b = b + 1) begin
				@(posedge i_clk);
				o_line <= f[b];
				repeat (15) @(posedge i_clk);
			end
			@(posedge i_clk);
			o_line <= 1'b1;
		end
	endtask
endmodule

// [test/ulf_top_tb.sv]
`timescale 1ns/1ps
module ulf_top_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0000;
	reg [3:0] nsmp = 4'h5;
	wire [15:0] rdata;
	wire tx, sir_n, rxv, pe, fe, rx;
	integer fails = 0;
	integer checked = 0;
	integer cyc = 0;
	integer i, j, nb;
	reg [15:0] v;
	reg [4:0] cfg;
	reg [7:0] d;
	localparam [19:0] FMTS = {5'h06, 5'h09, 5'h1f, 5'h04};
	localparam [43:0] FRMS = {11'h45a, 11'h25a, 11'h75a, 11'h65a};
	localparam [7:0] EFL = {2'h1, 2'h0, 2'h2, 2'h0};
	always #10 clk = ~clk;
	ulf_top dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata_q(rdata), .i_rx_pin(rx), .i_sir_in(1'b1), .o_tx_q(tx), .o_sir_out_n_q(sir_n),
		.o_rx_valid_q(rxv), .o_parity_err_q(pe), .o_frame_err_q(fe));
	ulf_remote rem (.i_clk(clk), .i_line(tx), .i_nsmp(nsmp), .o_line(rx));
	task final_report;
		begin
			$display("checked %0d fails %0d", checked, fails);
			if (fails == 0 && checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr_reg(input [3:0] a, input [15:0] dv);
		begin
			@(posedge clk);
			wr <= 1'b1;
			addr <= a;
			wdata <= dv;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rd_reg(input [3:0] a, output [15:0] dv);
		begin
			@(posedge clk);
			rd <= 1'b1;
			addr <= a;
			@(posedge clk);
			rd <= 1'b0;
			#1 dv = rdata;
		end
	endtask
	task wait_rx;
		integer n;
		begin
			n = 0;
			while (rxv !== 1'b1 && n < 500) begin
				@(posedge clk);
				#1 n = n + 1;
			end
			chk({15'h0000, rxv}, 16'h0001);
		end
	endtask
	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_reg(4'h3, v);
		chk(v, 16'h0000);
		for (i = 0; i < 4; i = i + 1) begin
			cfg = FMTS[i*5 +: 5];
			nb = 5 + cfg[1:0];
			nsmp <= nb + cfg[3];
			wr_reg(4'h3, {11'h000, cfg});
			rd_reg(4'h3, v);
			chk(v, {11'h000, cfg});
			wr_reg(4'h8, 16'h00a5);
			repeat (4) @(posedge clk);
			wr_reg(4'h8, 16'h003c);
			wr_reg(4'h3, {11'h000, ~cfg});
			rd_reg(4'h3, v);
			chk(v, {11'h000, cfg});
			repeat (420) @(posedge clk);
			j = 16 * (1 + nb + cfg[3]) + (cfg[2] ? (cfg[1:0] == 2'h0 ? 24 : 32) : 16);
			// One idle tick separates back-to-back characters
			chk(rem.period[15:0], j * 20 + 20);
			d = 8'h3c & ~(8'hff << nb);
			chk({7'h00, rem.smp} & ~(16'hffff << (nb + cfg[3])),
				{8'h00, d} | ({15'h0000, cfg[3] & (^d ^ ~cfg[4])} << nb));
		end
		wr_reg(4'h3, 16'h009f);
		wr_reg(4'h0, 16'h0001);
		rd_reg(4'h0, v);
		chk(v, 16'h0001);
		wr_reg(4'h3, 16'h001f);
		rd_reg(4'h0, v);
		chk(v, 16'h0000);
		rd_reg(4'hf, v);
		chk(v, 16'h0000);
		for (i = 0; i < 4; i = i + 1) begin
			fork
				rem.send(FRMS[i*11 +: 11], 11);
				wait_rx;
			join
			chk({14'h0000, pe, fe}, {14'h0000, EFL[i*2 +: 2]});
			rd_reg(4'h9, v);
			chk(v, 16'h005a);
			// A low second stop bit reads as a new start; let it drain
			repeat (200) @(posedge clk);
		end
		wr_reg(4'h3, 16'h005f);
		repeat (60) @(posedge clk);
		chk({15'h0000, tx}, 16'h0000);
		wr_reg(4'h3, 16'h001f);
		repeat (3) @(posedge clk);
		chk({15'h0000, tx}, 16'h0001);
		wr_reg(4'h4, 16'h0040);
		wr_reg(4'h3, 16'h005f);
		repeat (5) @(posedge clk);
		j = 0;
		repeat (64) begin
			@(posedge clk);
			#1 j = j + !sir_n;
		end
		chk(j[15:0], 16'h000c);
		wr_reg(4'h3, 16'h001f);
		repeat (20) @(posedge clk);
		wr_reg(4'h4, 16'h0050);
		wr_reg(4'h3, 16'h005f);
		wait_rx;
		chk({14'h0000, sir_n, fe}, 16'h0001);
		wr_reg(4'h3, 16'h001f);
		repeat (40) @(posedge clk);
		wr_reg(4'h4, 16'h0010);
		wr_reg(4'h8, 16'h0096);
		wait_rx;
		rd_reg(4'h9, v);
		chk(v, 16'h0096);
		chk({15'h0000, tx}, 16'h0001);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(4'h3, v);
		chk(v, 16'h0000);
		final_report;
	end
endmodule
